// file: rtl/scl_pkg.sv
package scl_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ        = 100;
	localparam int READY_TIME_US  = 5;
	localparam int READY_CYCLES   = READY_TIME_US * CLK_MHZ;
	localparam int SLOW_CLK_MHZ   = 20;
	localparam int SLOW_DIV       = CLK_MHZ / SLOW_CLK_MHZ;
	localparam int SLOW_HIGH      = SLOW_DIV / 2;
	localparam int SYNC_CYCLES    = 2;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] CFG_OFS    = 8'h00;
	localparam logic [7:0] IOBASE_OFS = 8'h04;
	localparam logic [7:0] GPDIR_OFS  = 8'h08;
	localparam logic [7:0] GPDAT_OFS  = 8'h0c;
	localparam logic [7:0] MODE_OFS   = 8'h10;

	// ------------------------------------------------------------
	// field positions and values
	// ------------------------------------------------------------
	localparam int NCR_EXT_BIT  = 7;
	localparam int OCR_EXT_BIT  = 5;
	localparam int MODE_OCR_LSB = 8;
	localparam logic [1:0] WIDTH_16  = 2'h0;
	localparam logic [1:0] WIDTH_32  = 2'h1;
	localparam logic [1:0] WIDTH_8   = 2'h2;
	localparam logic [1:0] WIDTH_RSV = 2'h3;
	localparam logic [9:0] IO_BASE_OFFSET = 10'h300;
	localparam logic [9:0] IO_BASE_STEP   = 10'h010;
	localparam logic [3:0] TEST_NORMAL    = 4'hc;
	localparam logic [6:0] GP_FIXED_OUT   = 7'h71;
	localparam logic [6:0] GP_DIR_RESET   = 7'h71;
	localparam logic [6:0] GP_DAT_RESET   = 7'h01;

	typedef struct packed {
		logic       width_hi;
		logic       width_lo;
		logic       led_mode;
		logic       irq_active_low;
		logic       irq_open_drain;
		logic [2:0] base_sel;
		logic       ext_mii;
		logic       reverse_mii;
		logic       ee_inhibit;
		logic       phy_up;
		logic       mdix_off;
	} scl_straps_t;

	typedef struct packed {
		logic speed_100;
		logic full_duplex;
		logic link_up;
		logic carrier;
	} scl_phy_stat_t;

endpackage

// file: rtl/scl_top.sv
// Behaviour
// - speed indicator driven low at 100 Mbit/s, floated at 10 Mbit/s.
// - LED mode 1: duplex indicator low at full duplex, floated at half.
// - LED mode 0: duplex indicator low at 10 Mbit/s, floated at 100.
// - LED mode 1: link/activity indicator shows link combined with carrier sense.
// - LED mode 0: link/activity indicator shows carrier sense only.
// - LED mode 1 when LED-mode strap is high, else mode 0.
// - clock source select 0 picks internal 100 MHz, 1 picks 20 MHz pin.
// - a 20 MHz clock output is provided for an external interface device.
// - device ready 5 us after power-on reset is released.
// - bus width from wake and data straps: 16, 32, 8, reserved.
// - interrupt polarity strap 1 gives active low, 0 active high.
// - outside 32-bit mode, I/O base is base strap times 10h plus 300h.
// - link-status output high while cable link is up, low otherwise.
// - outside 32-bit mode, external strap forces external mode, sets both bits.
// - EEPROM-inhibit strap skips the EEPROM load after power-on.
// - PHY powered after power-on when strap is 1, powered down when 0.
// - output-type strap 1 makes interrupt open-collector, 0 push-pull.
// - crossover detection on when strap reads 0, off when 1.
// - general pins 1-3 default inputs; pins 0 and 4-6 fixed outputs.
// - general pin 0 defaults high, which powers the PHY down.
// - host selected only by addr 9,8 high, 7 and enable low, mid bits match.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module scl_top #(
	parameter int GP_PINS = 7
) (
	// apb
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// strap pins
	input  wire scl_pkg::scl_straps_t strap_pins,
	input  wire logic [3:0]           operation_mode_inputs,
	input  wire logic                 clock_source_select,
	// internal phy and host side
	input  wire scl_pkg::scl_phy_stat_t phy_stat,
	input  wire logic                 irq_request,
	input  wire logic [9:4]           host_addr,
	input  wire logic                 addr_enable,
	// indicator and status pins
	output logic                      speed_indicator_o,
	output logic                      speed_indicator_oe,
	output logic                      duplex_indicator_o,
	output logic                      duplex_indicator_oe,
	output logic                      link_activity_indicator_o,
	output logic                      link_activity_indicator_oe,
	output logic                      link_status_o,
	output logic                      link_status_oe,
	output logic                      irq_o,
	output logic                      irq_oe,
	output logic                      slow_clock_output,
	// general pins
	input  wire logic [GP_PINS-1:0]   general_pins_i,
	output logic      [GP_PINS-1:0]   general_pins_o,
	output logic      [GP_PINS-1:0]   general_pins_oe,
	// configuration outputs
	output logic                      use_slow_clock,
	output logic                      dev_ready,
	output logic                      host_select,
	output logic                      ee_load_start,
	output logic [1:0]                bus_width,
	output logic                      reverse_mii,
	output logic                      ext_mii,
	output logic                      phy_power_up,
	output logic                      auto_mdix_en
);

	// ------------------------------------------------------------
	// decoders
	// ------------------------------------------------------------
	function automatic logic is_32bit(input scl_pkg::scl_straps_t s);
		return {s.width_hi, s.width_lo} == scl_pkg::WIDTH_32;
	endfunction

	function automatic logic [9:0] io_base(input logic [2:0] sel);
		return scl_pkg::IO_BASE_OFFSET + 10'(sel) * scl_pkg::IO_BASE_STEP;
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	localparam int SW = $bits(scl_pkg::scl_straps_t) + 5 + GP_PINS;

	logic [SW-1:0]        sync1_q;
	logic [SW-1:0]        sync2_q;
	scl_pkg::scl_straps_t strap_s;
	logic [3:0]           test_s;
	logic                 clksel_s;
	logic [GP_PINS-1:0]   gp_in_s;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {strap_pins, operation_mode_inputs, clock_source_select, general_pins_i};
			sync2_q <= sync1_q;
		end
	end

	assign {strap_s, test_s, clksel_s, gp_in_s} = sync2_q;

	// ------------------------------------------------------------
	// power-on sequence
	// ------------------------------------------------------------
	typedef enum logic [1:0] {ST_SYNC, ST_CAPTURE, ST_WAIT, ST_READY} scl_state_t;

	scl_state_t           state_q;
	logic [15:0]          cnt_q;
	scl_pkg::scl_straps_t cfg_q;
	logic                 cap_done_q;
	logic                 ee_start_q;

	// straps float when undriven, so pins sharing a strap stay off until capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= ST_SYNC;
			cnt_q      <= '0;
			cap_done_q <= 1'b0;
			ee_start_q <= 1'b0;
		end else begin
			ee_start_q <= 1'b0;
			case (state_q)
				ST_SYNC: begin
					cnt_q <= cnt_q + 16'h0001;
					if (cnt_q == 16'(scl_pkg::SYNC_CYCLES - 1)) begin
						state_q <= ST_CAPTURE;
					end
				end
				ST_CAPTURE: begin
					cnt_q      <= cnt_q + 16'h0001;
					cap_done_q <= 1'b1;
					state_q    <= ST_WAIT;
				end
				ST_WAIT: begin
					cnt_q <= cnt_q + 16'h0001;
					if (cnt_q == 16'(scl_pkg::READY_CYCLES - 1)) begin
						state_q    <= ST_READY;
						ee_start_q <= !cfg_q.ee_inhibit;
					end
				end
				ST_READY: begin
					state_q <= ST_READY;
				end
				default: begin
					state_q <= ST_SYNC;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= '0;
		end else if (state_q == ST_CAPTURE) begin
			cfg_q <= strap_s;
		end
	end

	assign dev_ready     = (state_q == ST_READY);
	assign ee_load_start = ee_start_q;

	// ------------------------------------------------------------
	// configuration decode
	// ------------------------------------------------------------
	logic in32;

	assign in32         = is_32bit(cfg_q);
	assign bus_width    = {cfg_q.width_hi, cfg_q.width_lo};
	assign reverse_mii  = cfg_q.reverse_mii;
	assign ext_mii      = cfg_q.ext_mii && !in32;
	assign auto_mdix_en = !cfg_q.mdix_off;
	assign host_select  = cap_done_q && !in32 && host_addr[9] && host_addr[8]
	                      && !host_addr[7] && !addr_enable
	                      && (host_addr[6:4] == cfg_q.base_sel);

	// ------------------------------------------------------------
	// clocks
	// ------------------------------------------------------------
	logic [2:0] div_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= '0;
		end else if (div_q == 3'(scl_pkg::SLOW_DIV - 1)) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 3'h1;
		end
	end

	// duty is 40/60 since the ratio is odd; fine for a clock input of an mii device
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_clock_output <= 1'b0;
		end else begin
			slow_clock_output <= (div_q < 3'(scl_pkg::SLOW_HIGH));
		end
	end

	assign use_slow_clock = clksel_s;

	// ------------------------------------------------------------
	// indicators
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed_indicator_oe         <= 1'b0;
			duplex_indicator_oe        <= 1'b0;
			link_activity_indicator_oe <= 1'b0;
			link_status_o              <= 1'b0;
		end else begin
			speed_indicator_oe <= phy_stat.speed_100;
			if (cfg_q.led_mode) begin
				duplex_indicator_oe        <= phy_stat.full_duplex;
				link_activity_indicator_oe <= phy_stat.link_up || phy_stat.carrier;
			end else begin
				duplex_indicator_oe        <= !phy_stat.speed_100;
				link_activity_indicator_oe <= phy_stat.carrier;
			end
			link_status_o <= phy_stat.link_up;
		end
	end

	assign speed_indicator_o         = 1'b0;
	assign duplex_indicator_o        = 1'b0;
	assign link_activity_indicator_o = 1'b0;
	assign link_status_oe            = cap_done_q;

	// ------------------------------------------------------------
	// interrupt pin
	// ------------------------------------------------------------
	logic irq_level;

	assign irq_level = irq_request ^ cfg_q.irq_active_low;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_o  <= 1'b0;
			irq_oe <= 1'b0;
		end else if (!cap_done_q) begin
			irq_o  <= 1'b0;
			irq_oe <= 1'b0;
		end else if (cfg_q.irq_open_drain) begin
			irq_o  <= 1'b0;
			irq_oe <= !irq_level;
		end else begin
			irq_o  <= irq_level;
			irq_oe <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// general pins
	// ------------------------------------------------------------
	logic [GP_PINS-1:0] gp_dir_q;
	logic [GP_PINS-1:0] gp_dat_q;
	logic               wr_en;
	logic               rd_en;

	assign wr_en = psel && penable && pwrite;
	// read data loads in the setup cycle so it already stands when pready is sampled
	assign rd_en = psel && !penable && !pwrite;

	// gp0 reloads from the power-up strap so a strapped-up phy is not held down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gp_dir_q <= scl_pkg::GP_DIR_RESET;
			gp_dat_q <= scl_pkg::GP_DAT_RESET;
		end else begin
			if (state_q == ST_CAPTURE) begin
				gp_dat_q[0] <= !strap_s.phy_up;
			end else if (wr_en && paddr == scl_pkg::GPDAT_OFS) begin
				gp_dat_q <= pwdata[GP_PINS-1:0];
			end
			if (wr_en && paddr == scl_pkg::GPDIR_OFS) begin
				gp_dir_q <= pwdata[GP_PINS-1:0] | scl_pkg::GP_FIXED_OUT;
			end
		end
	end

	assign general_pins_o  = gp_dat_q;
	assign general_pins_oe = cap_done_q ? gp_dir_q : '0;
	assign phy_power_up    = !gp_dat_q[0];

	// ------------------------------------------------------------
	// apb read side
	// ------------------------------------------------------------
	logic        mapped;
	logic [31:0] rd_mux;

	always_comb begin
		mapped = 1'b1;
		rd_mux = '0;
		case (paddr)
			scl_pkg::CFG_OFS:    rd_mux = {16'h0, test_s == scl_pkg::TEST_NORMAL,
			                               dev_ready, clksel_s, 13'(cfg_q)};
			scl_pkg::IOBASE_OFS: rd_mux = {21'h0, in32, io_base(cfg_q.base_sel)};
			scl_pkg::GPDIR_OFS:  rd_mux = 32'(gp_dir_q);
			scl_pkg::GPDAT_OFS:  rd_mux = 32'(gp_in_s);
			scl_pkg::MODE_OFS: begin
				rd_mux[scl_pkg::NCR_EXT_BIT]                       = ext_mii;
				rd_mux[scl_pkg::MODE_OCR_LSB + scl_pkg::OCR_EXT_BIT] = ext_mii;
			end
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (rd_en) begin
			prdata <= rd_mux;
		end
	end

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence capture_s;
		state_q == ST_CAPTURE;
	endsequence

	sequence ready_s;
		dev_ready && !$past(dev_ready);
	endsequence

	logic [15:0] since_cap_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since_cap_q <= '0;
		end else if (cap_done_q && !dev_ready) begin
			since_cap_q <= since_cap_q + 16'h0001;
		end
	end

	speed_led_a: assert property (presetn && phy_stat.speed_100 |=>
		speed_indicator_oe && !speed_indicator_o)
		else $error("speed indicator not driven low at 100M");
	duplex_m1_a: assert property (presetn && cfg_q.led_mode && $stable(cfg_q) |=>
		duplex_indicator_oe == $past(phy_stat.full_duplex))
		else $error("duplex indicator wrong in mode 1");
	duplex_m0_a: assert property (presetn && !cfg_q.led_mode && $stable(cfg_q) |=>
		duplex_indicator_oe == !$past(phy_stat.speed_100))
		else $error("duplex indicator wrong in mode 0");
	link_m1_a: assert property (presetn && cfg_q.led_mode && $stable(cfg_q) && phy_stat.link_up
		|=> link_activity_indicator_oe)
		else $error("link led not lit on link in mode 1");
	link_m0_a: assert property (presetn && !cfg_q.led_mode && $stable(cfg_q) |=>
		link_activity_indicator_oe == $past(phy_stat.carrier))
		else $error("link led not following carrier in mode 0");
	strap_hold_a: assert property (cap_done_q && !$rose(cap_done_q) |-> $stable(cfg_q))
		else $error("captured straps changed");
	ready_time_a: assert property (ready_s |-> since_cap_q == 16'(scl_pkg::READY_CYCLES - 3))
		else $error("ready not at 5 us");
	capture_a: assert property (capture_s |=> cfg_q == $past(strap_s) ##1 dev_ready == 1'b0)
		else $error("straps not captured");
	ee_load_a: assert property (ee_start_q |-> dev_ready && !cfg_q.ee_inhibit)
		else $error("eeprom load started while inhibited");
	link_out_a: assert property (phy_stat.link_up ##1 cap_done_q |-> link_status_o && link_status_oe)
		else $error("link status not high on link");
	irq_od_a: assert property (cap_done_q && cfg_q.irq_open_drain |=> !irq_o)
		else $error("open drain interrupt drove high");
	select_a: assert property (host_select |-> host_addr[6:4] == cfg_q.base_sel && !addr_enable)
		else $error("host selected on wrong address");
	gp_fixed_a: assert property (gp_dir_q[0] && gp_dir_q[4] && gp_dir_q[6:5] == 2'h3)
		else $error("fixed output general pin not output");

endmodule

`default_nettype wire

// file: tb/scl_board.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------
// board model: strap resistors, test pins, leds
// ------------------------------------------------
module scl_board (
	// strap choice from the bench
	input  wire scl_pkg::scl_straps_t sel,
	// pins toward the device
	output var scl_pkg::scl_straps_t  strap_pins,
	output logic [3:0]                test_pins,
	output logic [6:0]                gp_i,
	// pins from the device
	input  wire logic [6:0]           gp_o,
	input  wire logic [6:0]           gp_oe,
	input  wire logic [2:0]           led_o,
	input  wire logic [2:0]           led_oe,
	// lamp state seen by the bench
	output logic [2:0]                led_lit
);
	// pulled-high strap reads 1, floating strap reads 0 through the pull-down
	assign strap_pins = sel;
	assign test_pins = scl_pkg::TEST_NORMAL;
	// pull-downs: a released pin reads low, never the last driven value
	assign gp_i = gp_o & gp_oe;
	// lamp lights only while its pin is driven low
	assign led_lit = led_oe & ~led_o;
endmodule

`default_nettype wire

// file: tb/tb_scl_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_scl_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, slv, csel = 0, irq_req = 0, ae = 0;
	logic [5:0] ha = 6'h00;
	scl_pkg::scl_straps_t st = '0;
	scl_pkg::scl_straps_t sp;
	scl_pkg::scl_phy_stat_t ps = '0;
	logic [3:0] tp;
	logic [6:0] gpi, gpo, gpoe;
	wire logic [2:0] lo, loe;
	logic [2:0] lit;
	logic lso, lsoe, irqo, irqoe, sclk, usc, rdy, hs, eel, rev, ext, pup, mdx;
	logic [1:0] bw;
	int err_total = 0, num_checks = 0, n;

	always #5 pclk = ~pclk;

	scl_top dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.strap_pins(sp), .operation_mode_inputs(tp), .clock_source_select(csel),
		.phy_stat(ps), .irq_request(irq_req), .host_addr(ha), .addr_enable(ae),
		.speed_indicator_o(lo[2]), .speed_indicator_oe(loe[2]),
		.duplex_indicator_o(lo[1]), .duplex_indicator_oe(loe[1]),
		.link_activity_indicator_o(lo[0]), .link_activity_indicator_oe(loe[0]),
		.link_status_o(lso), .link_status_oe(lsoe), .irq_o(irqo), .irq_oe(irqoe),
		.slow_clock_output(sclk), .general_pins_i(gpi), .general_pins_o(gpo),
		.general_pins_oe(gpoe), .use_slow_clock(usc), .dev_ready(rdy), .host_select(hs),
		.ee_load_start(eel), .bus_width(bw), .reverse_mii(rev), .ext_mii(ext),
		.phy_power_up(pup), .auto_mdix_en(mdx)
	);

	scl_board board (
		.sel(st), .strap_pins(sp), .test_pins(tp), .gp_i(gpi), .gp_o(gpo), .gp_oe(gpoe),
		.led_o(lo), .led_oe(loe), .led_lit(lit)
	);

	// ------------------------------------------------
	// bench tasks
	// ------------------------------------------------
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task give_verdict;
		if (err_total == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// one apb transfer; request held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		slv = pslverr;
		rd = prdata;
		psel <= 0;
		penable <= 0;
	endtask

	// straps only count at reset release, so each set needs its own reset
	task rst(input scl_pkg::scl_straps_t s);
		@(posedge pclk);
		st <= s;
		presetn <= 0;
		@(posedge pclk);
		#1 chk(gpo, 32'h01);
		@(posedge pclk);
		presetn <= 1;
		n = 0;
		while (rdy !== 1'b1 && n < 600) begin
			@(posedge pclk);
			#1 n++;
		end
		chk(n, scl_pkg::READY_CYCLES);
		chk(eel, !s.ee_inhibit);
	endtask

	task leds(input logic m);
		for (int i = 0; i < 16; i++) begin
			@(posedge pclk);
			ps <= i[3:0];
			@(posedge pclk);
			@(posedge pclk);
			#1 chk(lit[2], ps.speed_100);
			chk(lit[1], m ? ps.full_duplex : !ps.speed_100);
			chk(lit[0], m ? (ps.link_up | ps.carrier) : ps.carrier);
			chk({lsoe, lso}, {1'b1, ps.link_up});
		end
	endtask

	task irqs(input logic al, input logic od);
		for (int i = 0; i < 2; i++) begin
			@(posedge pclk);
			irq_req <= i[0];
			@(posedge pclk);
			@(posedge pclk);
			#1 chk({irqoe, irqo}, od ? {!(i[0] ^ al), 1'b0} : {1'b1, i[0] ^ al});
		end
	endtask

	task hsel(input logic [6:0] v, input logic e);
		@(posedge pclk);
		{ae, ha} <= v;
		@(posedge pclk);
		#1 chk(hs, e);
	endtask

	// ------------------------------------------------
	// tests
	// ------------------------------------------------
	initial begin
		// led mode 1, 16-bit, base 5, external and reverse on, phy up
		rst(13'h06ba);
		chk(bw, scl_pkg::WIDTH_16);
		chk({rev, ext, pup, mdx}, 4'hf);
		apb(0, scl_pkg::IOBASE_OFS, 32'h0);
		chk(rd, 32'h350);
		apb(0, scl_pkg::MODE_OFS, 32'h0);
		chk(rd, 32'h2080);
		apb(0, scl_pkg::CFG_OFS, 32'h0);
		chk(rd, 32'hc6ba);
		apb(1, scl_pkg::CFG_OFS, 32'h0);
		@(posedge pclk);
		st <= 13'h1fff;
		repeat (6) @(posedge pclk);
		apb(0, scl_pkg::CFG_OFS, 32'h0);
		chk(rd, 32'hc6ba);
		chk(bw, scl_pkg::WIDTH_16);
		hsel(7'h35, 1);
		hsel(7'h75, 0);
		hsel(7'h25, 0);
		leds(1);
		apb(0, scl_pkg::GPDIR_OFS, 32'h0);
		chk(rd, 32'h71);
		apb(1, scl_pkg::GPDIR_OFS, 32'h0e);
		apb(0, scl_pkg::GPDIR_OFS, 32'h0);
		chk(rd, 32'h7f);
		chk(gpoe, 32'h7f);
		apb(1, scl_pkg::GPDAT_OFS, 32'h55);
		repeat (4) @(posedge pclk);
		apb(0, scl_pkg::GPDAT_OFS, 32'h0);
		chk(rd, 32'h55);
		chk(pup, 0);
		apb(1, scl_pkg::GPDIR_OFS, 32'h0);
		apb(0, scl_pkg::GPDIR_OFS, 32'h0);
		chk(rd, 32'h71);
		apb(0, 8'h20, 32'h0);
		chk(slv, 32'h1);
		chk(rd, 32'h0);
		@(posedge pclk);
		csel <= 1;
		repeat (4) @(posedge pclk);
		#1 chk(usc, 1);
		n = 0;
		repeat (10) begin
			@(posedge pclk);
			#1 n += sclk;
		end
		chk(n, 4);
		@(posedge pclk);
		csel <= 0;
		repeat (4) @(posedge pclk);
		#1 chk(usc, 0);
		// led mode 0, 32-bit, open-drain high-active irq, eeprom skipped, phy down
		rst(13'h0915);
		chk(bw, scl_pkg::WIDTH_32);
		chk({rev, ext, pup, mdx, gpo[0]}, 5'h01);
		apb(0, scl_pkg::MODE_OFS, 32'h0);
		chk(rd, 32'h0);
		hsel(7'h30, 0);
		leds(0);
		irqs(0, 1);
		// 8-bit, push-pull low-active irq, base 3
		rst(13'h1662);
		chk(bw, scl_pkg::WIDTH_8);
		apb(0, scl_pkg::IOBASE_OFS, 32'h0);
		chk(rd, 32'h330);
		irqs(1, 0);
		rst(13'h1800);
		chk(bw, scl_pkg::WIDTH_RSV);
		give_verdict;
	end

	initial begin
		#100000;
		err_total++;
		give_verdict;
	end
endmodule

`default_nettype wire
